/* include/gfm_consts.svh */
`ifndef GFM_CONSTS_SVH
`define GFM_CONSTS_SVH
`define GFM_ADDR_PIN0      8'h00
`define GFM_ADDR_PIN1      8'h04
`define GFM_ADDR_EVENT     8'h08
`define GFM_ADDR_ACLK      8'h0c
`define GFM_FN_MSB         6
`define GFM_DIR_BIT        8
`define GFM_POL_BIT        9
`define GFM_DBE_BIT        10
`define GFM_LVL_BIT        12
`define GFM_ACLK_EN_BIT    15
`define GFM_ACLK_DIV_MSB   4
`define GFM_FN_RESET       7'h01
`define GFM_DIV_RESET      5'h00
`define GFM_FN_GPIO        7'h01
`define GFM_FN_HPR_DONE    7'h30
`define GFM_FN_DSP_FIRST   7'h35
`define GFM_FN_DSP_LAST    7'h3c
`define GFM_FN_ASYNC_CLK   7'h3d
`define GFM_FN_BOOT_DONE   7'h44
`define GFM_FN_RAM2        7'h46
`define GFM_FN_RAM3        7'h47
`define GFM_FN_MCLK_ENA    7'h4b
`define GFM_FN_ACLK_ENA    7'h4c
`define GFM_FN_ISRC_FIRST  7'h4d
`define GFM_FN_ISRC_LAST   7'h4f
`define GFM_FN_HPL_NEG     7'h53
`define GFM_FN_HPR_NEG     7'h54
`define GFM_FN_HPL_POS     7'h55
`define GFM_FN_HPR_POS     7'h56
`define GFM_FN_SPK_SHORT   7'h5f
`define GFM_FN_SPK_SHDN    7'h61
`define GFM_RESP_OKAY      2'h0
`define GFM_RESP_SLVERR    2'h2
`define GFM_CLK_MHZ        125
`define GFM_DEBOUNCE_US    1000
`define GFM_DEBOUNCE_CYC   (`GFM_DEBOUNCE_US * `GFM_CLK_MHZ)
`define GFM_PULSE_NS       32
`define GFM_PULSE_CYC      ((`GFM_PULSE_NS * `GFM_CLK_MHZ + 999) / 1000)
`endif

/* include/gfm_pkg.sv */
package gfm_pkg;
  typedef struct packed {
    logic       hp_right_done;
    logic [7:0] dsp_status_flag;
    logic       boot_done;
    logic [1:0] dsp_ram_ready;
    logic       main_clock_enable;
    logic       async_clock_enable;
    logic [2:0] isrc_config_error;
    logic [3:0] hp_short;
    logic       spk_short;
    logic       spk_shutdown_done;
  } gfm_sources_t;

  typedef struct packed {
    logic [6:0] fn;
    logic       dir_out;
    logic       pol;
    logic       deb_en;
    logic       level;
  } gfm_pin_ctrl_t;

  typedef enum logic [1:0] {
    MODE_INPUT,
    MODE_OUTPUT,
    MODE_DRIVE,
    MODE_OFF
  } gfm_mode_t;
endpackage

/* rtl/gfm_io.sv */
// Functional notes
// - code 30h drives a short pulse after right headphone enable sequence completes.
// - codes 35h to 3Ch drive dsp status flags one to eight, high asserted.
// - code 3Dh drives a divided clock from the async system clock.
// - code 44h drives a short pulse when boot has completed.
// - codes 46h and 47h drive ram ready of dsp two and three.
// - codes 4Bh and 4Ch drive clock enable status, zero enabled.
// - codes 4Dh to 4Fh drive rate converter configuration error flags.
// - codes 53h to 56h drive the four headphone short circuit flags.
// - code 5Fh drives the speaker short circuit flag.
// - code 61h drives speaker shutdown completed status.
// - code 01h with the direction bit clear makes the pin an input for button or jack detect.
// - level field reads debounced input, ignoring polarity inversion.
// - debounced input edges trigger write sequencer rise and fall sequences.
// - debounced input raises an event on rising and falling edges.
// - edge event bits stay latched until cleared by software.
// - general output drives a static high or low level.
// - output value comes from the pin level bit.
// - in output mode the level field reads back the debounced pin level.
// - polarity bit set drives the inverse of the level bit.
`timescale 1ns/1ps
`include "gfm_consts.svh"
module gfm_io #(
  parameter int DEBOUNCE_CYCLES = `GFM_DEBOUNCE_CYC
) (
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic [7:0]            s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [7:0]            s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  input  wire gfm_pkg::gfm_sources_t sources,
  input  wire logic                  async_clk_tick,
  input  wire logic [1:0]            pin_i,
  output logic [1:0]                 pin_o,
  output logic [1:0]                 pin_oe,
  output logic [1:0]                 seq_rise,
  output logic [1:0]                 seq_fall,
  output logic [3:0]                 event_status
);
  localparam logic [16:0] DEB_LAST = 17'(DEBOUNCE_CYCLES - 1);
  localparam logic [2:0]  PULSE_LEN = 3'(`GFM_PULSE_CYC);

  // register file state
  gfm_pkg::gfm_pin_ctrl_t ctrl_reg [2];
  gfm_pkg::gfm_pin_ctrl_t ctrl_next [2];
  logic [3:0]  ev_reg;
  logic [3:0]  ev_next;
  logic        aclk_en_reg;
  logic        aclk_en_next;
  logic [4:0]  aclk_div_reg;
  logic [4:0]  aclk_div_next;

  // bus state
  logic        aw_held_reg;
  logic        aw_held_next;
  logic [7:0]  aw_addr_reg;
  logic [7:0]  aw_addr_next;
  logic        w_held_reg;
  logic        w_held_next;
  logic [31:0] w_data_reg;
  logic [31:0] w_data_next;
  logic [3:0]  w_strb_reg;
  logic [3:0]  w_strb_next;
  logic        bvalid_reg;
  logic        bvalid_next;
  logic [1:0]  bresp_reg;
  logic [1:0]  bresp_next;
  logic        rvalid_reg;
  logic        rvalid_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic [1:0]  rresp_reg;
  logic [1:0]  rresp_next;

  // per pin and source signals
  logic [1:0]  deb_level;
  logic [1:0]  rise_ev;
  logic [1:0]  fall_ev;
  logic [1:0]  stretched;
  logic [1:0]  pulse_src;
  logic        aclk_out_reg;
  logic        aclk_out_next;
  logic [4:0]  aclk_cnt_reg;
  logic [4:0]  aclk_cnt_next;

  logic        do_write;
  assign do_write      = aw_held_reg && w_held_reg && !bvalid_reg;
  assign s_axi_awready = !aw_held_reg && !bvalid_reg;
  assign s_axi_wready  = !w_held_reg && !bvalid_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;
  assign event_status  = ev_reg;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        r[b*8 +: 8] = d[b*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [31:0] ctrl_word(input gfm_pkg::gfm_pin_ctrl_t c, input logic lvl);
    logic [31:0] r;
    r = 32'h0000_0000;
    r[`GFM_FN_MSB:0] = c.fn;
    r[`GFM_DIR_BIT]  = c.dir_out;
    r[`GFM_POL_BIT]  = c.pol;
    r[`GFM_DBE_BIT]  = c.deb_en;
    r[`GFM_LVL_BIT]  = lvl;
    return r;
  endfunction

  function automatic gfm_pkg::gfm_pin_ctrl_t ctrl_field(input logic [31:0] w);
    gfm_pkg::gfm_pin_ctrl_t c;
    c.fn      = w[`GFM_FN_MSB:0];
    c.dir_out = w[`GFM_DIR_BIT];
    c.pol     = w[`GFM_POL_BIT];
    c.deb_en  = w[`GFM_DBE_BIT];
    c.level   = w[`GFM_LVL_BIT];
    return c;
  endfunction

  // status source selected by a function code
  function automatic logic src_bit(input logic [6:0] fn, input gfm_pkg::gfm_sources_t s,
                                   input logic [1:0] st, input logic ck);
    logic r;
    r = 1'b0;
    if (fn >= `GFM_FN_DSP_FIRST && fn <= `GFM_FN_DSP_LAST) begin
      r = s.dsp_status_flag[3'(fn - `GFM_FN_DSP_FIRST)];
    end else if (fn >= `GFM_FN_ISRC_FIRST && fn <= `GFM_FN_ISRC_LAST) begin
      r = s.isrc_config_error[2'(fn - `GFM_FN_ISRC_FIRST)];
    end else begin
      case (fn)
        `GFM_FN_HPR_DONE:  r = st[0];
        `GFM_FN_ASYNC_CLK: r = ck;
        `GFM_FN_BOOT_DONE: r = st[1];
        `GFM_FN_RAM2:      r = s.dsp_ram_ready[0];
        `GFM_FN_RAM3:      r = s.dsp_ram_ready[1];
        `GFM_FN_MCLK_ENA:  r = !s.main_clock_enable;
        `GFM_FN_ACLK_ENA:  r = !s.async_clock_enable;
        `GFM_FN_HPL_NEG:   r = s.hp_short[0];
        `GFM_FN_HPR_NEG:   r = s.hp_short[1];
        `GFM_FN_HPL_POS:   r = s.hp_short[2];
        `GFM_FN_HPR_POS:   r = s.hp_short[3];
        `GFM_FN_SPK_SHORT: r = s.spk_short;
        `GFM_FN_SPK_SHDN:  r = s.spk_shutdown_done;
        default:           r = 1'b0;
      endcase
    end
    return r;
  endfunction

  function automatic logic fn_known(input logic [6:0] fn);
    logic k;
    k = (fn >= `GFM_FN_DSP_FIRST && fn <= `GFM_FN_ASYNC_CLK) ||
        (fn >= `GFM_FN_MCLK_ENA && fn <= `GFM_FN_ISRC_LAST) ||
        (fn >= `GFM_FN_HPL_NEG && fn <= `GFM_FN_HPR_POS) ||
        fn == `GFM_FN_HPR_DONE || fn == `GFM_FN_BOOT_DONE ||
        fn == `GFM_FN_RAM2 || fn == `GFM_FN_RAM3 ||
        fn == `GFM_FN_SPK_SHORT || fn == `GFM_FN_SPK_SHDN;
    return k;
  endfunction

  // bus and register file
  always_comb begin
    logic [31:0] wv;
    wv            = 32'h0000_0000;
    aw_held_next  = aw_held_reg;
    aw_addr_next  = aw_addr_reg;
    w_held_next   = w_held_reg;
    w_data_next   = w_data_reg;
    w_strb_next   = w_strb_reg;
    bvalid_next   = bvalid_reg;
    bresp_next    = bresp_reg;
    rvalid_next   = rvalid_reg;
    rdata_next    = rdata_reg;
    rresp_next    = rresp_reg;
    ctrl_next     = ctrl_reg;
    aclk_en_next  = aclk_en_reg;
    aclk_div_next = aclk_div_reg;
    ev_next       = ev_reg;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_held_next = 1'b1;
      aw_addr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_held_next = 1'b1;
      w_data_next = s_axi_wdata;
      w_strb_next = s_axi_wstrb;
    end
    if (bvalid_reg && s_axi_bready) begin
      bvalid_next = 1'b0;
    end
    if (do_write) begin
      aw_held_next = 1'b0;
      w_held_next  = 1'b0;
      bvalid_next  = 1'b1;
      bresp_next   = `GFM_RESP_OKAY;
      case (aw_addr_reg)
        `GFM_ADDR_PIN0: begin
          wv = merge(ctrl_word(ctrl_reg[0], ctrl_reg[0].level), w_data_reg, w_strb_reg);
          ctrl_next[0] = ctrl_field(wv);
        end
        `GFM_ADDR_PIN1: begin
          wv = merge(ctrl_word(ctrl_reg[1], ctrl_reg[1].level), w_data_reg, w_strb_reg);
          ctrl_next[1] = ctrl_field(wv);
        end
        `GFM_ADDR_EVENT: begin
          if (w_strb_reg[0]) begin
            ev_next = ev_reg & ~w_data_reg[3:0];
          end
        end
        `GFM_ADDR_ACLK: begin
          wv = 32'h0000_0000;
          wv[`GFM_ACLK_EN_BIT] = aclk_en_reg;
          wv[`GFM_ACLK_DIV_MSB:0] = aclk_div_reg;
          wv = merge(wv, w_data_reg, w_strb_reg);
          aclk_en_next  = wv[`GFM_ACLK_EN_BIT];
          aclk_div_next = wv[`GFM_ACLK_DIV_MSB:0];
        end
        default: bresp_next = `GFM_RESP_SLVERR;
      endcase
    end
    // a new edge wins over a clear in the same cycle
    ev_next = ev_next | {fall_ev[1], rise_ev[1], fall_ev[0], rise_ev[0]};
    if (rvalid_reg && s_axi_rready) begin
      rvalid_next = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_next = 1'b1;
      rresp_next  = `GFM_RESP_OKAY;
      rdata_next  = 32'h0000_0000;
      case (s_axi_araddr)
        `GFM_ADDR_PIN0:  rdata_next = ctrl_word(ctrl_reg[0], deb_level[0]);
        `GFM_ADDR_PIN1:  rdata_next = ctrl_word(ctrl_reg[1], deb_level[1]);
        `GFM_ADDR_EVENT: rdata_next[3:0] = ev_reg;
        `GFM_ADDR_ACLK: begin
          rdata_next[`GFM_ACLK_EN_BIT] = aclk_en_reg;
          rdata_next[`GFM_ACLK_DIV_MSB:0] = aclk_div_reg;
        end
        default: rresp_next = `GFM_RESP_SLVERR;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg  <= 1'b0;
      aw_addr_reg  <= 8'h00;
      w_held_reg   <= 1'b0;
      w_data_reg   <= 32'h0000_0000;
      w_strb_reg   <= 4'h0;
      bvalid_reg   <= 1'b0;
      bresp_reg    <= `GFM_RESP_OKAY;
      rvalid_reg   <= 1'b0;
      rdata_reg    <= 32'h0000_0000;
      rresp_reg    <= `GFM_RESP_OKAY;
      for (int p = 0; p < 2; p++) begin
        ctrl_reg[p] <= '{fn: `GFM_FN_RESET, dir_out: 1'b0, pol: 1'b0, deb_en: 1'b0, level: 1'b0};
      end
      ev_reg       <= 4'h0;
      aclk_en_reg  <= 1'b0;
      aclk_div_reg <= `GFM_DIV_RESET;
    end else begin
      aw_held_reg  <= aw_held_next;
      aw_addr_reg  <= aw_addr_next;
      w_held_reg   <= w_held_next;
      w_data_reg   <= w_data_next;
      w_strb_reg   <= w_strb_next;
      bvalid_reg   <= bvalid_next;
      bresp_reg    <= bresp_next;
      rvalid_reg   <= rvalid_next;
      rdata_reg    <= rdata_next;
      rresp_reg    <= rresp_next;
      ctrl_reg     <= ctrl_next;
      ev_reg       <= ev_next;
      aclk_en_reg  <= aclk_en_next;
      aclk_div_reg <= aclk_div_next;
    end
  end

  // async clock output: toggles once every div ticks, div 0 acts as 1
  always_comb begin
    aclk_cnt_next = aclk_cnt_reg;
    aclk_out_next = aclk_out_reg;
    if (!aclk_en_reg) begin
      aclk_cnt_next = 5'h00;
      aclk_out_next = 1'b0;
    end else if (async_clk_tick) begin
      if (aclk_cnt_reg + 5'h01 >= aclk_div_reg) begin
        aclk_cnt_next = 5'h00;
        aclk_out_next = !aclk_out_reg;
      end else begin
        aclk_cnt_next = aclk_cnt_reg + 5'h01;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aclk_cnt_reg <= 5'h00;
      aclk_out_reg <= 1'b0;
    end else begin
      aclk_cnt_reg <= aclk_cnt_next;
      aclk_out_reg <= aclk_out_next;
    end
  end

  assign pulse_src = {sources.boot_done, sources.hp_right_done};

  // completion events stretched to a short fixed pulse
  for (genvar g = 0; g < 2; g++) begin : g_pulse
    logic       prev_reg;
    logic [2:0] cnt_reg;
    logic [2:0] cnt_next;
    always_comb begin
      cnt_next = cnt_reg;
      if (pulse_src[g] && !prev_reg) begin
        cnt_next = PULSE_LEN;
      end else if (cnt_reg != 3'h0) begin
        cnt_next = cnt_reg - 3'h1;
      end
    end
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        prev_reg <= 1'b0;
        cnt_reg  <= 3'h0;
      end else begin
        prev_reg <= pulse_src[g];
        cnt_reg  <= cnt_next;
      end
    end
    assign stretched[g] = cnt_reg != 3'h0;
  end

  for (genvar g = 0; g < 2; g++) begin : g_pin
    logic                meta_reg;
    logic                sync_reg;
    logic                deb_reg;
    logic                deb_next;
    logic [16:0]         cnt_reg;
    logic [16:0]         cnt_next;
    logic                rise_reg;
    logic                fall_reg;
    logic                o_reg;
    logic                o_next;
    logic                oe_reg;
    logic                oe_next;
    gfm_pkg::gfm_mode_t  mode;
    logic                is_input;

    always_comb begin
      if (ctrl_reg[g].fn == `GFM_FN_GPIO) begin
        mode = ctrl_reg[g].dir_out ? gfm_pkg::MODE_OUTPUT : gfm_pkg::MODE_INPUT;
      end else if (fn_known(ctrl_reg[g].fn)) begin
        mode = gfm_pkg::MODE_DRIVE;
      end else begin
        mode = gfm_pkg::MODE_OFF;
      end
    end
    assign is_input = mode == gfm_pkg::MODE_INPUT;

    always_comb begin
      deb_next = deb_reg;
      cnt_next = 17'h0_0000;
      if (!ctrl_reg[g].deb_en) begin
        deb_next = sync_reg;
      end else if (sync_reg != deb_reg) begin
        if (cnt_reg >= DEB_LAST) begin
          deb_next = sync_reg;
        end else begin
          cnt_next = cnt_reg + 17'h0_0001;
        end
      end
      unique case (mode)
        gfm_pkg::MODE_INPUT: begin
          o_next  = 1'b0;
          oe_next = 1'b0;
        end
        gfm_pkg::MODE_OUTPUT: begin
          o_next  = ctrl_reg[g].level ^ ctrl_reg[g].pol;
          oe_next = 1'b1;
        end
        gfm_pkg::MODE_DRIVE: begin
          o_next  = src_bit(ctrl_reg[g].fn, sources, stretched, aclk_out_reg) ^ ctrl_reg[g].pol;
          oe_next = 1'b1;
        end
        gfm_pkg::MODE_OFF: begin
          o_next  = 1'b0;
          oe_next = 1'b0;
        end
      endcase
    end

    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        meta_reg <= 1'b0;
        sync_reg <= 1'b0;
        deb_reg  <= 1'b0;
        cnt_reg  <= 17'h0_0000;
        rise_reg <= 1'b0;
        fall_reg <= 1'b0;
        o_reg    <= 1'b0;
        oe_reg   <= 1'b0;
      end else begin
        meta_reg <= pin_i[g];
        sync_reg <= meta_reg;
        deb_reg  <= deb_next;
        cnt_reg  <= cnt_next;
        rise_reg <= is_input && deb_next && !deb_reg;
        fall_reg <= is_input && !deb_next && deb_reg;
        o_reg    <= o_next;
        oe_reg   <= oe_next;
      end
    end

    assign deb_level[g] = deb_reg;
    assign rise_ev[g]   = rise_reg;
    assign fall_ev[g]   = fall_reg;
    assign seq_rise[g]  = rise_reg;
    assign seq_fall[g]  = fall_reg;
    assign pin_o[g]     = o_reg;
    assign pin_oe[g]    = oe_reg;
  end
endmodule

/* tb/gfm_button_model.sv */
`timescale 1ns/1ps
module gfm_button_model (
  input  wire logic [1:0] btn,
  input  wire logic [1:0] chat,
  input  wire logic       aclk,
  input  wire logic [1:0] pin_o,
  input  wire logic [1:0] pin_oe,
  output logic      [1:0] pin_i
);
  logic [1:0] lvl_reg = 2'h0;
  // a bouncing contact flips every cycle until it settles on the button state
  always @(posedge aclk) lvl_reg <= (chat & ~lvl_reg) | (~chat & btn);
  // the pin shows the device while it drives, the contact otherwise
  assign pin_i = (pin_oe & pin_o) | (~pin_oe & lvl_reg);
endmodule

/* tb/gfm_io_asserts.sv */
`timescale 1ns/1ps
module gfm_io_asserts #(
  parameter int DEBOUNCE_CYCLES = 4
) (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [1:0]  pin_i,
  input wire logic [1:0]  seq_rise,
  input wire logic [1:0]  seq_fall,
  input wire logic [3:0]  event_status
);
  logic [2:0] wr_age_reg;
  logic [2:0] wr_age_next;
  // cycles since the last write data beat, saturating
  always_comb begin
    wr_age_next = wr_age_reg;
    if (s_axi_wvalid && s_axi_wready) wr_age_next = 3'h0;
    else if (wr_age_reg != 3'h7) wr_age_next = wr_age_reg + 3'h1;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) wr_age_reg <= 3'h7;
    else wr_age_reg <= wr_age_next;
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence aw_hs; s_axi_awvalid && s_axi_awready; endsequence
  sequence w_hs; s_axi_wvalid && s_axi_wready; endsequence
  sequence ar_hs; s_axi_arvalid && s_axi_arready; endsequence
  wr_resp_a: assert property ((aw_hs and w_hs) |-> ##2 s_axi_bvalid)
    else $error("write response late");
  rd_resp_a: assert property (ar_hs |=> s_axi_rvalid)
    else $error("read response late");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read response dropped");
  rise_cause_a: assert property (seq_rise[0] |-> $past(pin_i[0], 3) ##1 event_status[0])
    else $error("rise pulse without cause");
  fall_cause_a: assert property (seq_fall[0] |-> !$past(pin_i[0], 3) ##1 event_status[1])
    else $error("fall pulse without cause");
  edge_pulse_a: assert property ((|seq_rise) |=> (seq_rise & $past(seq_rise)) == 2'h0)
    else $error("edge pulse too long");
  ev_hold_a: assert property ($past(aresetn) && (|(~event_status & $past(event_status))) |-> wr_age_reg <= 3'h3)
    else $error("event cleared without write");
endmodule

bind gfm_io gfm_io_asserts #(.DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)) u_gfm_io_asserts (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .pin_i(pin_i), .seq_rise(seq_rise), .seq_fall(seq_fall),
  .event_status(event_status)
);

/* tb/tb_gfm_io.sv */
`timescale 1ns/1ps
`include "gfm_consts.svh"
module tb_gfm_io;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, tick, awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp, pin_i, pin_o, pin_oe, seq_rise, seq_fall, btn, chat;
  logic [3:0] ev;
  logic p;
  gfm_pkg::gfm_sources_t src;
  integer error_cnt, compares, seed, nrise, nfall, ev_m, rise_m, fall_m, k;
  logic [6:0] codes [21] = '{7'h35, 7'h36, 7'h37, 7'h38, 7'h39, 7'h3a, 7'h3b, 7'h3c, 7'h46, 7'h47,
                             7'h4b, 7'h4c, 7'h4d, 7'h4e, 7'h4f, 7'h53, 7'h54, 7'h55, 7'h56, 7'h5f, 7'h61};

  gfm_io #(.DEBOUNCE_CYCLES(4)) u_gfm_io (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .sources(src), .async_clk_tick(tick), .pin_i(pin_i),
    .pin_o(pin_o), .pin_oe(pin_oe), .seq_rise(seq_rise), .seq_fall(seq_fall), .event_status(ev)
  );
  gfm_button_model u_btn (.btn(btn), .chat(chat), .aclk(aclk), .pin_o(pin_o), .pin_oe(pin_oe), .pin_i(pin_i));

  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    if (seq_rise[0] === 1'b1) nrise++;
    if (seq_fall[0] === 1'b1) nfall++;
    if (seq_rise[1] === 1'b1) nrise++;
    if (seq_fall[1] === 1'b1) nfall++;
  end

  task automatic test_done;
    $display("compares %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk_reg(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic chk_pin(input string nm, input logic e, input logic g);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s exp %b got %b", nm, e, g);
    end
  endtask
  task automatic cyc(input integer n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic wchk(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    integer n, dly;
    n = 0;
    dly = $random(seed) & 3;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (n > dly) bready <= 1'b1;
    end while (!(bvalid && bready));
    bready <= 1'b0;
    chk_reg("bresp", {30'h0, er}, {30'h0, bresp});
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    integer n, dly;
    n = 0;
    dly = $random(seed) & 3;
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arready) arvalid <= 1'b0;
      if (n > dly) rready <= 1'b1;
    end while (!(rvalid && rready));
    rready <= 1'b0;
    chk_reg("rdata", e, rdata);
    chk_reg("rresp", {30'h0, er}, {30'h0, rresp});
  endtask
  task automatic chk_ev;
    chk_reg("events", ev_m, {28'h0, ev});
    chk_reg("rises", rise_m, nrise);
    chk_reg("falls", fall_m, nfall);
  endtask
  function automatic logic fn_exp(input logic [6:0] f, input gfm_pkg::gfm_sources_t s);
    if (f >= 7'h35 && f <= 7'h3c) return s.dsp_status_flag[f - 7'h35];
    if (f >= 7'h4d && f <= 7'h4f) return s.isrc_config_error[f - 7'h4d];
    if (f >= 7'h53 && f <= 7'h56) return s.hp_short[f - 7'h53];
    case (f)
      7'h46: return s.dsp_ram_ready[0];
      7'h47: return s.dsp_ram_ready[1];
      7'h4b: return !s.main_clock_enable;
      7'h4c: return !s.async_clock_enable;
      7'h5f: return s.spk_short;
      default: return s.spk_shutdown_done;
    endcase
  endfunction

  initial begin
    repeat (20000) @(posedge aclk);
    error_cnt++;
    test_done;
  end
  initial begin
    seed = 32'h02cf1863;
    {error_cnt, compares, nrise, nfall, ev_m, rise_m, fall_m} = '0;
    {aresetn, awvalid, wvalid, bready, arvalid, rready, tick, awaddr, araddr, wdata, btn, chat} = '0;
    src = '0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rchk(8'h00, 32'h0000_0001, 2'h0);
    rchk(8'h04, 32'h0000_0001, 2'h0);
    rchk(8'h08, 32'h0000_0000, 2'h0);
    rchk(8'h0c, 32'h0000_0000, 2'h0);
    rchk(8'h10, 32'h0000_0000, 2'h2);
    wchk(8'h14, 32'hffff_ffff, 2'h2);
    chk_pin("reset oe", 1'b0, pin_oe[0]);
    btn[0] <= 1'b1;
    cyc(8);
    ev_m |= 1;
    rise_m++;
    chk_ev;
    rchk(8'h00, 32'h0000_1001, 2'h0);
    btn[0] <= 1'b0;
    cyc(8);
    ev_m |= 2;
    fall_m++;
    chk_ev;
    wchk(8'h08, 32'h0000_0001, 2'h0);
    ev_m &= 2;
    chk_ev;
    rchk(8'h08, 32'h0000_0002, 2'h0);
    wchk(8'h00, 32'h0000_0201, 2'h0);
    btn[0] <= 1'b1;
    cyc(8);
    rise_m++;
    rchk(8'h00, 32'h0000_1201, 2'h0);
    wchk(8'h08, 32'h0000_000f, 2'h0);
    ev_m = 0;
    wchk(8'h00, 32'h0000_0401, 2'h0);
    chat[0] <= 1'b1;
    cyc(6);
    chat[0] <= 1'b0;
    cyc(12);
    chk_ev;
    btn[0] <= 1'b0;
    cyc(12);
    ev_m |= 2;
    fall_m++;
    chk_ev;
    for (int v = 0; v < 4; v++) begin
      wchk(8'h00, {19'h0, v[0], 2'b00, v[1], 9'h101}, 2'h0);
      cyc(3);
      chk_pin("out oe", 1'b1, pin_oe[0]);
      chk_pin("out level", v[0] ^ v[1], pin_o[0]);
      cyc(6);
      rchk(8'h00, {19'h0, v[0] ^ v[1], 2'b00, v[1], 9'h101}, 2'h0);
    end
    chk_ev;
    wchk(8'h00, 32'h0000_0001, 2'h0);
    foreach (codes[i]) begin
      p = $random(seed);
      wchk(8'h04, {22'h0, p, 2'b00, codes[i]}, 2'h0);
      repeat (2) begin
        src <= gfm_pkg::gfm_sources_t'($random(seed));
        cyc(3);
        chk_pin("status oe", 1'b1, pin_oe[1]);
        chk_pin("status", fn_exp(codes[i], src) ^ p, pin_o[1]);
      end
    end
    for (int i = 0; i < 2; i++) begin
      src <= '0;
      wchk(8'h04, (i == 0) ? 32'h0000_0030 : 32'h0000_0044, 2'h0);
      cyc(2);
      if (i == 0) src.hp_right_done <= 1'b1;
      else src.boot_done <= 1'b1;
      k = 0;
      repeat (12) begin
        @(posedge aclk);
        k += pin_o[1];
      end
      chk_reg("pulse width", `GFM_PULSE_CYC, k);
    end
    tick <= 1'b1;
    wchk(8'h0c, 32'h0000_8003, 2'h0);
    rchk(8'h0c, 32'h0000_8003, 2'h0);
    wchk(8'h04, 32'h0000_003d, 2'h0);
    cyc(2);
    repeat (2) begin
      p = pin_o[1];
      k = 0;
      do begin
        @(posedge aclk);
        k++;
      end while (pin_o[1] === p && k < 20);
    end
    chk_reg("clock half period", 3, k);
    wchk(8'h0c, 32'h0000_0000, 2'h0);
    cyc(3);
    chk_pin("clock off", 1'b0, pin_o[1]);
    wchk(8'h04, 32'h0000_0002, 2'h0);
    cyc(3);
    chk_pin("off oe", 1'b0, pin_oe[1]);
    wchk(8'h04, 32'h0000_0001, 2'h0);
    btn[1] <= 1'b1;
    cyc(8);
    ev_m |= 4;
    rise_m++;
    chk_ev;
    btn[1] <= 1'b0;
    cyc(8);
    ev_m |= 8;
    fall_m++;
    chk_ev;
    wchk(8'h08, 32'h0000_000c, 2'h0);
    ev_m &= 3;
    chk_ev;
    test_done;
  end
endmodule
